// file: core/csr_pkg.sv
package csr_pkg;
   // Special register addresses inside the global bank
   localparam logic [7:0] CSR_ADDR_INDIRECT = 8'h00;
   localparam logic [7:0] CSR_ADDR_TIMER = 8'h01;
   localparam logic [7:0] CSR_ADDR_PPLOW = 8'h02;
   localparam logic [7:0] CSR_ADDR_STATUS = 8'h03;
   localparam logic [7:0] CSR_ADDR_BANK = 8'h04;
   // Status register field positions
   localparam int CSR_ST_PAGE_MSB = 7;
   localparam int CSR_ST_PAGE_LSB = 5;
   localparam int CSR_ST_WDOG = 4;
   localparam int CSR_ST_SLEEP = 3;
   localparam int CSR_ST_ZERO = 2;
   localparam int CSR_ST_NIBBLE = 1;
   localparam int CSR_ST_CARRY = 0;
   // Bits that a status write may change
   localparam logic [7:0] CSR_ST_WR_MASK = 8'he7;
   // Bank pointer fields
   localparam int CSR_BANK_BLOCK = 7;
   localparam logic [7:0] CSR_BANK_CMD_MASK = 8'h70;
   // Reset values
   localparam logic [7:0] CSR_STATUS_RESET = 8'h18;
   localparam logic [7:0] CSR_BANK_RESET = 8'h00;
   localparam logic [7:0] CSR_ACC_RESET = 8'h00;
   localparam logic [7:0] CSR_TIMER_RESET = 8'h00;
   localparam logic [7:0] CSR_PRESCALE_RESET = 8'h00;
   // Program pointer
   localparam int CSR_PP_WIDTH = 11;
   localparam int CSR_PP_TARGET_W = 12;
   localparam logic [11:0] CSR_PP_RESET = 12'hfff;
   // Fuse level that enables an option (fuses are programmed to 0)
   localparam logic CSR_FUSE_ON = 1'b0;

   typedef enum logic [5:0] {
      CSR_ALU_NONE = 6'h01,
      CSR_ALU_ADD = 6'h02,
      CSR_ALU_SUB = 6'h04,
      CSR_ALU_ZERO = 6'h08,
      CSR_ALU_RR = 6'h10,
      CSR_ALU_RL = 6'h20
   } csr_alu_op_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] field;
      logic [7:0] wdata;
   } csr_file_req_t;

   typedef struct packed {
      logic accum_select;
      logic from_pin;
      logic falling;
      logic prescale_to_timer;
      logic [2:0] rate;
   } csr_timer_opt_t;

   typedef struct packed {
      logic valid;
      csr_alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
   } csr_alu_req_t;

   typedef struct packed {
      logic advance;
      logic skip;
      logic jump;
      logic call;
      logic load;
      logic [11:0] target;
   } csr_flow_t;
endpackage

// file: core/csr_event_timer.sv
`timescale 1ns/1ns
module csr_event_timer (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Configuration and pin
   input csr_pkg::csr_timer_opt_t opt,
   input wire logic timer_pin,
   // Software load
   input wire logic load,
   input wire logic [7:0] load_value,
   // Count and wrap
   output logic [7:0] count,
   output logic wrap
);
   import csr_pkg::*;

   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_last_reg;
   logic [7:0] pre_reg;
   logic [7:0] pre_mask;
   logic edge_seen;
   logic event_in;
   logic inc;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_last_reg <= 1'b0;
      end else begin
         pin_meta_reg <= timer_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   // Rate n divides by 2^(n+1)
   assign pre_mask = 8'((9'h002 << opt.rate) - 9'h001);
   assign edge_seen = opt.falling ? (pin_last_reg & ~pin_sync_reg)
                                  : (~pin_last_reg & pin_sync_reg);
   assign event_in = opt.from_pin ? edge_seen : 1'b1;
   assign inc = event_in & (~opt.prescale_to_timer | ((pre_reg & pre_mask) == pre_mask));

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pre_reg <= CSR_PRESCALE_RESET;
      end else if (event_in && opt.prescale_to_timer) begin
         pre_reg <= pre_reg + 8'h01;
      end
   end

   // A load in the same cycle as a tick wins; the tick is dropped
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count <= CSR_TIMER_RESET;
         wrap <= 1'b0;
      end else if (load) begin
         count <= load_value;
         wrap <= 1'b0;
      end else begin
         if (inc) begin
            count <= count + 8'h01;
         end
         wrap <= inc && (count == 8'hff);
      end
   end
endmodule

// file: core/csr_special_regs.sv
`timescale 1ns/1ns
module csr_special_regs #(
   parameter int PP_W = csr_pkg::CSR_PP_WIDTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Fuses
   input wire logic option_extend_fuse,
   input wire logic carry_input_fuse,
   // Timer configuration, pin and interrupt enable
   input csr_pkg::csr_timer_opt_t timer_opt,
   input wire logic event_timer_pin,
   input wire logic timer_irq_enable,
   // File register access from the core
   input csr_pkg::csr_file_req_t file_req,
   output logic [7:0] file_rd_data,
   output logic file_rd_valid,
   // Data memory side
   output logic mem_wr,
   output logic mem_rd,
   output logic [7:0] mem_addr,
   output logic mem_global,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // Accumulator port
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] working_accumulator,
   // Flag producing operations
   input csr_pkg::csr_alu_req_t alu_req,
   output logic [7:0] alu_result,
   output logic alu_result_valid,
   // Instruction events
   input wire logic watchdog_timeout,
   input wire logic clear_watchdog_cmd,
   input wire logic sleep_cmd,
   input wire logic page_cmd,
   input wire logic [2:0] page_value,
   input wire logic bank_cmd,
   input wire logic [7:0] bank_value,
   input csr_pkg::csr_flow_t flow,
   // Visible state
   output logic [7:0] core_status,
   output logic [7:0] bank_pointer,
   output logic [7:0] event_timer_count,
   output logic [PP_W-1:0] program_pointer,
   output logic timer_irq_req,
   output logic accum_mapped
);
   import csr_pkg::*;

   logic opt_fuse_reg;
   logic carry_fuse_reg;
   logic [7:0] eff_addr;
   logic eff_global;
   logic eff_none;
   logic is_local;
   logic [7:0] local_value;
   logic wr_timer;
   logic wr_acc;
   logic wr_pplow;
   logic wr_status;
   logic wr_bank;
   logic [7:0] timer_count;
   logic timer_wrap;
   logic [7:0] status_next;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_upd_c;
   logic alu_upd_dc;
   logic alu_upd_z;
   logic cin;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] b_eff;
   logic s1_read_reg;
   logic s1_local_reg;
   logic [7:0] s1_value_reg;
   logic [CSR_PP_TARGET_W-1:0] jump_target;
   logic [CSR_PP_TARGET_W-1:0] call_target;

   // Fuses are static words; a register keeps them off the decode path
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         opt_fuse_reg <= ~CSR_FUSE_ON;
         carry_fuse_reg <= ~CSR_FUSE_ON;
      end else begin
         opt_fuse_reg <= option_extend_fuse;
         carry_fuse_reg <= carry_input_fuse;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         accum_mapped <= 1'b0;
      end else begin
         accum_mapped <= (opt_fuse_reg == CSR_FUSE_ON) && !timer_opt.accum_select;
      end
   end

   // Address resolution
   always_comb begin
      eff_addr = 8'h00;
      eff_global = 1'b1;
      eff_none = 1'b0;
      if (file_req.field == 5'h00) begin
         eff_addr = bank_pointer;
         eff_global = (bank_pointer[7:4] == 4'h0);
         eff_none = (bank_pointer == CSR_ADDR_INDIRECT);
      end else if (!file_req.field[4]) begin
         eff_addr = {3'b000, file_req.field};
      end else begin
         // Low pointer bits play no part here
         eff_addr = {bank_pointer[7:4], file_req.field[3:0]};
         eff_global = 1'b0;
      end
   end

   assign is_local = eff_global && !eff_none && (eff_addr >= CSR_ADDR_TIMER)
                     && (eff_addr <= CSR_ADDR_BANK);

   always_comb begin
      local_value = 8'h00;
      case (eff_addr)
         CSR_ADDR_TIMER: local_value = accum_mapped ? working_accumulator
                                                    : timer_count;
         CSR_ADDR_PPLOW: local_value = program_pointer[7:0];
         CSR_ADDR_STATUS: local_value = core_status;
         CSR_ADDR_BANK: local_value = bank_pointer;
         default: local_value = 8'h00;
      endcase
   end

   assign wr_timer = file_req.wr && is_local && (eff_addr == CSR_ADDR_TIMER) && !accum_mapped;
   assign wr_acc = file_req.wr && is_local && (eff_addr == CSR_ADDR_TIMER) && accum_mapped;
   assign wr_pplow = file_req.wr && is_local && (eff_addr == CSR_ADDR_PPLOW);
   assign wr_status = file_req.wr && is_local && (eff_addr == CSR_ADDR_STATUS);
   assign wr_bank = file_req.wr && is_local && (eff_addr == CSR_ADDR_BANK);

   // General registers go out one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= 8'h00;
         mem_global <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         mem_wr <= file_req.wr && !is_local && !eff_none;
         mem_rd <= file_req.rd && !is_local && !eff_none;
         mem_addr <= eff_addr;
         mem_global <= eff_global;
         mem_wdata <= file_req.wdata;
      end
   end

   // Uniform two-cycle read latency for local and memory reads
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_read_reg <= 1'b0;
         s1_local_reg <= 1'b0;
         s1_value_reg <= 8'h00;
      end else begin
         s1_read_reg <= file_req.rd;
         s1_local_reg <= is_local || eff_none;
         s1_value_reg <= eff_none ? 8'h00 : local_value;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         file_rd_data <= 8'h00;
         file_rd_valid <= 1'b0;
      end else begin
         file_rd_valid <= s1_read_reg;
         file_rd_data <= s1_local_reg ? s1_value_reg : mem_rdata;
      end
   end

   csr_event_timer u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .opt(timer_opt),
      .timer_pin(event_timer_pin),
      .load(wr_timer),
      .load_value(file_req.wdata),
      .count(timer_count),
      .wrap(timer_wrap)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         event_timer_count <= CSR_TIMER_RESET;
         timer_irq_req <= 1'b0;
      end else begin
         event_timer_count <= timer_count;
         timer_irq_req <= timer_wrap && timer_irq_enable;
      end
   end

   // Mapped write wins over the direct port in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         working_accumulator <= CSR_ACC_RESET;
      end else if (wr_acc) begin
         working_accumulator <= file_req.wdata;
      end else if (acc_wr) begin
         working_accumulator <= acc_wdata;
      end
   end

   // Flag producing arithmetic
   always_comb begin
      b_eff = (alu_req.op == CSR_ALU_SUB) ? ~alu_req.b : alu_req.b;
      if (carry_fuse_reg == CSR_FUSE_ON) begin
         cin = core_status[CSR_ST_CARRY];
      end else begin
         cin = (alu_req.op == CSR_ALU_SUB);
      end
      sum9 = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, cin};
      sum5 = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      alu_res = alu_req.a;
      alu_c = core_status[CSR_ST_CARRY];
      alu_dc = core_status[CSR_ST_NIBBLE];
      alu_upd_c = 1'b0;
      alu_upd_dc = 1'b0;
      alu_upd_z = 1'b0;
      case (alu_req.op)
         CSR_ALU_ADD, CSR_ALU_SUB: begin
            // Subtract keeps carry as not-borrow
            alu_res = sum9[7:0];
            alu_c = sum9[8];
            alu_dc = sum5[4];
            alu_upd_c = 1'b1;
            alu_upd_dc = 1'b1;
            alu_upd_z = 1'b1;
         end
         CSR_ALU_ZERO: begin
            alu_res = alu_req.a;
            alu_upd_z = 1'b1;
         end
         CSR_ALU_RR: begin
            alu_res = {core_status[CSR_ST_CARRY], alu_req.a[7:1]};
            alu_c = alu_req.a[0];
            alu_upd_c = 1'b1;
         end
         CSR_ALU_RL: begin
            alu_res = {alu_req.a[6:0], core_status[CSR_ST_CARRY]};
            alu_c = alu_req.a[7];
            alu_upd_c = 1'b1;
         end
         default: begin
            alu_res = alu_req.a;
         end
      endcase
      if (!alu_req.valid) begin
         alu_upd_c = 1'b0;
         alu_upd_dc = 1'b0;
         alu_upd_z = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         alu_result <= 8'h00;
         alu_result_valid <= 1'b0;
      end else begin
         alu_result <= alu_res;
         alu_result_valid <= alu_req.valid;
      end
   end

   // Status: write first, page command, then instruction flags on top
   always_comb begin
      status_next = core_status;
      if (wr_status) begin
         status_next = (core_status & ~CSR_ST_WR_MASK)
                     | (file_req.wdata & CSR_ST_WR_MASK);
      end
      if (page_cmd) begin
         status_next[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB] = page_value;
      end
      if (alu_upd_z) begin
         status_next[CSR_ST_ZERO] = (alu_res == 8'h00);
      end
      if (alu_upd_dc) begin
         status_next[CSR_ST_NIBBLE] = alu_dc;
      end
      if (alu_upd_c) begin
         status_next[CSR_ST_CARRY] = alu_c;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         core_status[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB] <= CSR_STATUS_RESET[7:5];
         core_status[CSR_ST_ZERO:CSR_ST_CARRY] <= CSR_STATUS_RESET[2:0];
      end else begin
         core_status[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB] <=
            status_next[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB];
         core_status[CSR_ST_ZERO:CSR_ST_CARRY] <= status_next[CSR_ST_ZERO:CSR_ST_CARRY];
      end
   end

   // Watchdog flag; a timeout beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         core_status[CSR_ST_WDOG] <= CSR_STATUS_RESET[CSR_ST_WDOG];
      end else if (watchdog_timeout) begin
         core_status[CSR_ST_WDOG] <= 1'b0;
      end else if (clear_watchdog_cmd || sleep_cmd) begin
         core_status[CSR_ST_WDOG] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         core_status[CSR_ST_SLEEP] <= CSR_STATUS_RESET[CSR_ST_SLEEP];
      end else if (sleep_cmd) begin
         core_status[CSR_ST_SLEEP] <= 1'b0;
      end else if (clear_watchdog_cmd) begin
         core_status[CSR_ST_SLEEP] <= 1'b1;
      end
   end

   // Bank command touches bits 4..6 only; block bit needs a full write
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bank_pointer <= CSR_BANK_RESET;
      end else if (wr_bank) begin
         bank_pointer <= file_req.wdata;
      end else if (bank_cmd) begin
         bank_pointer <= (bank_pointer & ~CSR_BANK_CMD_MASK)
                       | (bank_value & CSR_BANK_CMD_MASK);
      end
   end

   // Page bits sit above a 9-bit jump field; calls reach the first half page
   assign jump_target = {core_status[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB], flow.target[8:0]};
   assign call_target = {core_status[CSR_ST_PAGE_MSB:CSR_ST_PAGE_LSB], 1'b0,
                         flow.target[7:0]};

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         program_pointer <= CSR_PP_RESET[PP_W-1:0];
      end else if (wr_pplow) begin
         program_pointer[7:0] <= file_req.wdata;
      end else if (flow.jump) begin
         program_pointer <= jump_target[PP_W-1:0];
      end else if (flow.call) begin
         program_pointer <= call_target[PP_W-1:0];
      end else if (flow.load) begin
         program_pointer <= flow.target[PP_W-1:0];
      end else if (flow.skip) begin
         program_pointer <= program_pointer + PP_W'(2);
      end else if (flow.advance) begin
         program_pointer <= program_pointer + PP_W'(1);
      end
   end
endmodule

// file: sim/csr_special_regs_assertions.sv
`timescale 1ns/1ns
module csr_special_regs_assertions #(
   parameter int PP_W = 11
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched inputs
   input wire logic carry_input_fuse,
   input csr_pkg::csr_file_req_t file_req,
   input csr_pkg::csr_alu_req_t alu_req,
   input wire logic watchdog_timeout,
   input wire logic clear_watchdog_cmd,
   input wire logic sleep_cmd,
   input wire logic page_cmd,
   input wire logic [2:0] page_value,
   input csr_pkg::csr_flow_t flow,
   // Watched outputs
   input wire logic file_rd_valid,
   input wire logic mem_rd,
   input wire logic [7:0] mem_addr,
   input wire logic mem_global,
   input wire logic [7:0] alu_result,
   input wire logic [7:0] core_status,
   input wire logic [7:0] bank_pointer,
   input wire logic [PP_W-1:0] program_pointer
);
   import csr_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic [8:0] add9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
   wire logic [4:0] add5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
   // Page and ALU events in the same cycle override a status write; watchdog and sleep events change bits 4:3
   wire logic quiet = !alu_req.valid && !page_cmd && !watchdog_timeout && !clear_watchdog_cmd
      && !sleep_cmd;
   sequence s_mem_fetch;
      mem_rd ##1 file_rd_valid;
   endsequence
   a_status_write: assert property (
      file_req.wr && file_req.field == 5'h03 && quiet |=>
      (core_status & CSR_ST_WR_MASK) == ($past(file_req.wdata) & CSR_ST_WR_MASK)
      && core_status[4:3] == $past(core_status[4:3])) else $error("status write wrong");
   a_timeout_clears: assert property (watchdog_timeout |=> !core_status[4])
      else $error("timeout flag not cleared");
   a_clear_sets: assert property (
      clear_watchdog_cmd && !watchdog_timeout && !sleep_cmd |=> core_status[4:3] == 2'b11)
      else $error("clear command flags wrong");
   a_sleep_flags: assert property (
      sleep_cmd && !watchdog_timeout |=> core_status[4:3] == 2'b10)
      else $error("sleep flags wrong");
   a_page_only: assert property (
      page_cmd && !file_req.wr && !alu_req.valid |=> core_status[7:5] == $past(page_value)
      && core_status[2:0] == $past(core_status[2:0])) else $error("page command wrong");
   a_read_answer: assert property (file_req.rd |-> ##2 file_rd_valid)
      else $error("read answer late");
   a_indirect_addr: assert property (
      file_req.rd && file_req.field == 5'h00 && bank_pointer > 8'h04 |=> mem_rd
      && mem_addr == $past(bank_pointer) && mem_global == ($past(bank_pointer) < 8'h10))
      else $error("indirect address wrong");
   a_semi_direct: assert property (
      file_req.rd && file_req.field[4] |=> (!mem_global
      && mem_addr == {$past(bank_pointer[7:4]), $past(file_req.field[3:0])}) ##0 s_mem_fetch)
      else $error("banked address wrong");
   a_add_flags: assert property (
      alu_req.valid && alu_req.op == CSR_ALU_ADD && carry_input_fuse && $past(carry_input_fuse)
      |=> core_status[2:0] == {$past(add9[7:0]) == 8'h00, $past(add5[4]), $past(add9[8])})
      else $error("add flags wrong");
   a_rotate_right: assert property (
      alu_req.valid && alu_req.op == CSR_ALU_RR |=> core_status[0] == $past(alu_req.a[0])
      && alu_result == {$past(core_status[0]), $past(alu_req.a[7:1])})
      else $error("rotate right wrong");
   a_pp_advance: assert property (
      flow.advance && !flow.skip && !flow.jump && !flow.call && !flow.load && !file_req.wr
      |=> program_pointer == PP_W'($past(program_pointer) + 1'b1))
      else $error("pointer advance wrong");
endmodule

bind csr_special_regs csr_special_regs_assertions #(.PP_W(PP_W)) u_csr_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .carry_input_fuse(carry_input_fuse),
   .file_req(file_req), .alu_req(alu_req), .watchdog_timeout(watchdog_timeout),
   .clear_watchdog_cmd(clear_watchdog_cmd), .sleep_cmd(sleep_cmd), .page_cmd(page_cmd),
   .page_value(page_value), .flow(flow), .file_rd_valid(file_rd_valid), .mem_rd(mem_rd),
   .mem_addr(mem_addr), .mem_global(mem_global), .alu_result(alu_result),
   .core_status(core_status), .bank_pointer(bank_pointer), .program_pointer(program_pointer)
);

// file: sim/core_special_register_file_tb.sv
`timescale 1ns/1ns
module core_special_register_file_tb;
   import csr_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, option_extend_fuse = 1'b1, carry_input_fuse = 1'b1;
   logic event_timer_pin = 1'b0, timer_irq_enable = 1'b0, acc_wr = 1'b0;
   logic watchdog_timeout = 1'b0, clear_watchdog_cmd = 1'b0, sleep_cmd = 1'b0;
   logic page_cmd = 1'b0, bank_cmd = 1'b0, mg;
   logic [2:0] page_value = 3'h5;
   logic [7:0] acc_wdata = 8'h00, bank_value = 8'h00, mem_rdata = 8'h6c, rv, ma, v;
   csr_timer_opt_t timer_opt = '{accum_select: 1'b1, default: '0};
   csr_file_req_t file_req = '0;
   csr_alu_req_t alu_req = '{op: CSR_ALU_NONE, default: '0};
   csr_flow_t flow = '0;
   logic [7:0] file_rd_data, mem_addr, mem_wdata, working_accumulator, alu_result;
   logic [7:0] core_status, bank_pointer, event_timer_count;
   logic file_rd_valid, mem_wr, mem_rd, mem_global, alu_result_valid, timer_irq_req;
   logic accum_mapped;
   logic [10:0] program_pointer, p;
   int n_fail = 0, checks = 0;

   always #4 ref_clk = ~ref_clk;

   csr_special_regs #(.PP_W(11)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .option_extend_fuse(option_extend_fuse),
      .carry_input_fuse(carry_input_fuse), .timer_opt(timer_opt),
      .event_timer_pin(event_timer_pin), .timer_irq_enable(timer_irq_enable),
      .file_req(file_req), .file_rd_data(file_rd_data), .file_rd_valid(file_rd_valid),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_global(mem_global),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
      .working_accumulator(working_accumulator), .alu_req(alu_req), .alu_result(alu_result),
      .alu_result_valid(alu_result_valid), .watchdog_timeout(watchdog_timeout),
      .clear_watchdog_cmd(clear_watchdog_cmd), .sleep_cmd(sleep_cmd), .page_cmd(page_cmd),
      .page_value(page_value), .bank_cmd(bank_cmd), .bank_value(bank_value), .flow(flow),
      .core_status(core_status), .bank_pointer(bank_pointer),
      .event_timer_count(event_timer_count), .program_pointer(program_pointer),
      .timer_irq_req(timer_irq_req), .accum_mapped(accum_mapped)
   );

   task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task automatic wr(input logic [4:0] f, input logic [7:0] d);
      file_req = '{rd: 1'b0, wr: 1'b1, field: f, wdata: d};
      cyc(1);
      file_req = '0;
      cyc(1);
   endtask
   // Bounded wait so a lost answer fails the check instead of hanging
   task automatic rd(input logic [4:0] f);
      ma = 8'h00;
      mg = 1'bx;
      file_req = '{rd: 1'b1, wr: 1'b0, field: f, wdata: 8'h00};
      for (int i = 0; i < 4 && !file_rd_valid; i++) begin
         cyc(1);
         file_req = '0;
         if (mem_rd) begin
            ma = mem_addr;
            mg = mem_global;
         end
      end
      chk("read answer", file_rd_valid, 1'b1);
      rv = file_rd_data;
      cyc(1);
   endtask
   task automatic alu(input csr_alu_op_t op, input logic [7:0] a, b, r, input logic [2:0] fl);
      alu_req = '{valid: 1'b1, op: op, a: a, b: b};
      cyc(1);
      alu_req.valid = 1'b0;
      if (!alu_result_valid) cyc(1);
      chk("alu result", alu_result, r);
      chk("alu flags", core_status[2:0], fl);
      cyc(1);
   endtask

   task automatic t_status;
      chk("status reset", core_status, 8'h18);
      chk("pointer reset", program_pointer, 11'h7ff);
      wr(5'h03, 8'hff);
      rd(5'h03);
      chk("status read", rv, 8'hff);
      wr(5'h03, 8'h00);
      chk("status write", core_status, 8'h18);
      pulse(watchdog_timeout);
      chk("timeout", core_status, 8'h08);
      wr(5'h03, 8'hff);
      chk("status keep", core_status, 8'hef);
      pulse(sleep_cmd);
      chk("sleep", core_status, 8'hf7);
      pulse(clear_watchdog_cmd);
      chk("clear", core_status, 8'hff);
      wr(5'h03, 8'h00);
      $display("t_status done");
   endtask
   task automatic t_page_bank;
      pulse(page_cmd);
      chk("page", core_status, 8'hb8);
      bank_value = 8'hff;
      pulse(bank_cmd);
      chk("bank cmd", bank_pointer, 8'h70);
      wr(5'h04, 8'h80);
      bank_value = 8'h20;
      pulse(bank_cmd);
      chk("bank block", bank_pointer, 8'ha0);
      rd(5'h1f);
      chk("banked addr", {mg, ma}, 9'h0af);
      wr(5'h04, 8'hf5);
      rd(5'h00);
      chk("indirect addr", {mg, ma}, 9'h0f5);
      chk("indirect data", rv, 8'h6c);
      file_req = '{rd: 1'b0, wr: 1'b1, field: 5'h00, wdata: 8'h9e};
      cyc(1);
      chk("mem write", {mem_wr, mem_wdata}, 9'h19e);
      file_req = '0;
      cyc(1);
      wr(5'h04, 8'h08);
      rd(5'h00);
      chk("global addr", {mg, ma}, 9'h108);
      wr(5'h04, 8'h00);
      rd(5'h00);
      chk("no storage", rv, 8'h00);
      $display("t_page_bank done");
   endtask
   task automatic t_alu;
      alu(CSR_ALU_ADD, 8'h0f, 8'h01, 8'h10, 3'b010);
      alu(CSR_ALU_ADD, 8'hff, 8'h01, 8'h00, 3'b111);
      alu(CSR_ALU_SUB, 8'h10, 8'h01, 8'h0f, 3'b001);
      alu(CSR_ALU_SUB, 8'h00, 8'h01, 8'hff, 3'b000);
      alu(CSR_ALU_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
      alu(CSR_ALU_RR, 8'h02, 8'h00, 8'h81, 3'b110);
      alu(CSR_ALU_RL, 8'h80, 8'h00, 8'h00, 3'b111);
      carry_input_fuse = 1'b0;
      cyc(2);
      alu(CSR_ALU_ADD, 8'h01, 8'h01, 8'h03, 3'b000);
      alu(CSR_ALU_SUB, 8'h05, 8'h02, 8'h02, 3'b011);
      carry_input_fuse = 1'b1;
      cyc(2);
      $display("t_alu done");
   endtask
   task automatic t_timer;
      v = event_timer_count;
      cyc(4);
      chk("tick", event_timer_count, 8'(v + 8'h04));
      timer_irq_enable = 1'b1;
      wr(5'h01, 8'hf0);
      for (int i = 0; i < 40 && !timer_irq_req; i++) cyc(1);
      chk("wrap request", timer_irq_req, 1'b1);
      timer_irq_enable = 1'b0;
      wr(5'h01, 8'hf8);
      rv = 8'h00;
      for (int i = 0; i < 30; i++) begin
         cyc(1);
         rv = rv | timer_irq_req;
      end
      chk("masked wrap", rv, 8'h00);
      timer_opt.from_pin = 1'b1;
      for (int e = 0; e < 2; e++) begin
         timer_opt.falling = e[0];
         cyc(6);
         v = event_timer_count;
         repeat (3) begin
            event_timer_pin = 1'b1;
            cyc(3);
            event_timer_pin = 1'b0;
            cyc(3);
         end
         cyc(6);
         chk("pin edges", event_timer_count, 8'(v + 8'h03));
      end
      timer_opt = '{accum_select: 1'b1, prescale_to_timer: 1'b1, default: '0};
      cyc(1);
      v = event_timer_count;
      cyc(8);
      chk("prescaled", event_timer_count, 8'(v + 8'h04));
      timer_opt = '{accum_select: 1'b1, default: '0};
      $display("t_timer done");
   endtask
   task automatic t_accum;
      option_extend_fuse = 1'b0;
      timer_opt.accum_select = 1'b0;
      cyc(3);
      chk("mapped", accum_mapped, 1'b1);
      acc_wdata = 8'h5a;
      pulse(acc_wr);
      rd(5'h01);
      chk("acc read", rv, 8'h5a);
      wr(5'h01, 8'h3c);
      chk("acc write", working_accumulator, 8'h3c);
      option_extend_fuse = 1'b1;
      cyc(3);
      chk("unmapped", accum_mapped, 1'b0);
      timer_opt.accum_select = 1'b1;
      $display("t_accum done");
   endtask
   task automatic t_pointer;
      p = program_pointer;
      flow.advance = 1'b1;
      cyc(3);
      flow.advance = 1'b0;
      cyc(1);
      chk("advance", program_pointer, 11'(p + 11'h003));
      flow = '{jump: 1'b1, target: 12'h123, default: '0};
      cyc(1);
      flow = '0;
      cyc(1);
      chk("jump", program_pointer, 11'h323);
      flow = '{call: 1'b1, target: 12'h0c4, default: '0};
      cyc(1);
      flow = '0;
      cyc(1);
      chk("call", program_pointer, 11'h2c4);
      wr(5'h02, 8'h55);
      rd(5'h02);
      chk("low byte", rv, 8'h55);
      $display("t_pointer done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Tests need under 1000 cycles; ten times that is a hang
   initial begin
      #80000;
      n_fail++;
      finish_test;
   end

   initial begin
      cyc(10);
      rst_n = 1'b1;
      t_status;
      t_page_bank;
      t_alu;
      t_timer;
      t_accum;
      t_pointer;
      finish_test;
   end
endmodule
